// File: fheu_fault_unit.v
// fault classification, escalation, status capture and lockup of the core
//
// Summary of operation
// - bus errors and internal errors raise faults
// - no-execute fetch or protection trip faults
// - vector read error: hard fault, flag
// - escalation sets escalation flag
// - protection faults flag their access kind
// - no-execute fetch flags regardless of protection
// - bus errors flag their phase kind
// - usage faults flag each cause
// - bad isa or continuation return flags
// - programmable priority and per-handler enable
// - priority and masks decide entry
// - same-kind fault in handler escalates
// - not-higher fault in fault handler escalates
// - not-higher fault in any handler escalates
// - disabled handler fault escalates
// - bus fault entering bus handler stays
// - hard fault preempts all but nmi and hard
// - protect and bus faults except inexact capture address
// - hard fault in nmi or hard locks
// - lockup ends by reset, nmi, halt
// - lockup from nmi ignores further nmi
// - invalid return code raises usage fault
`timescale 1ns/1ns
`include "fheu_regs.vh"
module fheu_fault_unit (
  input wire i_ref_clk,
  input wire i_reset,
  // ahb-lite register port
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output wire o_hreadyout,
  output wire o_hresp,
  output reg [31:0] o_hrdata,
  // fault reports from pipeline, protection check and bus
  input wire i_fault_valid,
  input wire [4:0] i_fault_cause,
  input wire [31:0] i_fault_addr,
  input wire i_bus_handler_entry,
  // internally detected pipeline conditions
  input wire i_ret_check,
  input wire [31:0] i_ret_value,
  input wire i_handler_mode,
  input wire i_bad_isa,
  input wire i_ici_bad_return,
  // current execution context and masks
  input wire [2:0] i_cur_kind,
  input wire [7:0] i_cur_prio,
  input wire i_primask,
  input wire i_faultmask,
  input wire [7:0] i_basepri,
  // lockup release sources
  input wire i_nmi,
  input wire i_debug_halt,
  // handler dispatch and lockup
  output reg o_take_valid,
  output reg [2:0] o_take_handler,
  output reg o_lockup
);

  // ----------
  // helper functions
  // ----------
  // return code legality
  function ret_code_ok;
    input [31:0] val;
    begin
      ret_code_ok = (val[31:5] == `FHEU_RET_UPPER) &&
        ((val[4:0] == `FHEU_RET_H_MSP) || (val[4:0] == `FHEU_RET_T_MSP) ||
         (val[4:0] == `FHEU_RET_T_PSP) || (val[4:0] == `FHEU_RET_H_MSP_FP) ||
         (val[4:0] == `FHEU_RET_T_MSP_FP) || (val[4:0] == `FHEU_RET_T_PSP_FP));
    end
  endfunction

  // handler kind that a cause belongs to
  function [2:0] cause_kind;
    input [4:0] c;
    begin
      if (c == `FHEU_C_VECTOR) begin
        cause_kind = `FHEU_K_HARD;
      end else if (c <= `FHEU_C_PROT_LAZY_FP) begin
        cause_kind = `FHEU_K_PROTECT;
      end else if (c <= `FHEU_C_BUS_INEXACT) begin
        cause_kind = `FHEU_K_BUS;
      end else begin
        cause_kind = `FHEU_K_USAGE;
      end
    end
  endfunction

  // one-hot flag in combined status for a cause
  function [31:0] cause_flag;
    input [4:0] c;
    begin
      cause_flag = 32'h00000000;
      if ((c >= `FHEU_C_PROT_INSTR) && (c <= `FHEU_C_PROT_LAZY_FP)) begin
        cause_flag[c - `FHEU_C_PROT_INSTR] = 1'b1;
      end else if ((c >= `FHEU_C_BUS_STACK) && (c <= `FHEU_C_BUS_INEXACT)) begin
        cause_flag[c - `FHEU_C_BUS_STACK + 5'h08] = 1'b1;
      end else if ((c >= `FHEU_C_USE_COPROC) && (c <= `FHEU_C_USE_ZERO_DIV)) begin
        cause_flag[c - `FHEU_C_USE_COPROC + 5'h10] = 1'b1;
      end
    end
  endfunction

  // ----------
  // declarations
  // ----------
  wire wr_en;
  wire rd_en;
  wire [7:0] dp_addr;
  wire esc_raw;

  reg [31:0] combined_fault_status_r;
  reg [31:0] combined_fault_status_nxt;
  reg [31:0] hard_fault_status_r;
  reg [31:0] hard_fault_status_nxt;
  reg [31:0] protect_fault_address_r;
  reg [31:0] bus_fault_address_r;
  reg [2:0] handler_enable_r;
  reg [7:0] prio_protect_r;
  reg [7:0] prio_bus_r;
  reg [7:0] prio_usage_r;
  reg lock_from_nmi_r;

  reg ret_bad;
  reg state_bad;
  reg ev_valid;
  reg [4:0] ev_cause;
  reg [2:0] ev_kind;
  reg ev_enabled;
  reg [7:0] ev_prio;
  reg escalate;
  reg [2:0] target;
  reg to_lock;
  reg [31:0] cfs_clr;
  reg [31:0] hfs_clr;
  reg [31:0] cfs_set;
  reg prot_capture;
  reg bus_capture;

  // ----------
  // register bus and escalation submodules
  // ----------
  fheu_ahb_slave u_ahb (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hsize(i_hsize),
    .i_hready(i_hready),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_wr_en(wr_en),
    .o_rd_en(rd_en),
    .o_dp_addr(dp_addr)
  );

  fheu_escalate u_esc (
    .i_kind(ev_kind),
    .i_enabled(ev_enabled),
    .i_prio(ev_prio),
    .i_cur_kind(i_cur_kind),
    .i_cur_prio(i_cur_prio),
    .i_primask(i_primask),
    .i_faultmask(i_faultmask),
    .i_basepri(i_basepri),
    .i_bus_handler_entry(i_bus_handler_entry),
    .o_escalate(esc_raw)
  );

  // ----------
  // event selection and classification
  // ----------
  // external reports win; internal checks are only seen in a free cycle
  always @* begin
    ret_bad = i_ret_check & i_handler_mode & ~ret_code_ok(i_ret_value);
    state_bad = i_bad_isa | i_ici_bad_return;
    ev_valid = ~o_lockup & (i_fault_valid | ret_bad | state_bad);
    if (i_fault_valid) begin
      ev_cause = i_fault_cause;
    end else if (ret_bad) begin
      ev_cause = `FHEU_C_USE_BAD_RETURN;
    end else begin
      ev_cause = `FHEU_C_USE_BAD_STATE;
    end
    ev_kind = cause_kind(ev_cause);
    case (ev_kind)
      `FHEU_K_PROTECT: begin
        ev_enabled = handler_enable_r[`FHEU_BIT_EN_PROTECT];
        ev_prio = prio_protect_r;
      end
      `FHEU_K_BUS: begin
        ev_enabled = handler_enable_r[`FHEU_BIT_EN_BUS];
        ev_prio = prio_bus_r;
      end
      `FHEU_K_USAGE: begin
        ev_enabled = handler_enable_r[`FHEU_BIT_EN_USAGE];
        ev_prio = prio_usage_r;
      end
      default: begin
        ev_enabled = 1'b1;
        ev_prio = 8'h00;
      end
    endcase
  end

  // ----------
  // handler target and lockup decision
  // ----------
  always @* begin
    escalate = esc_raw & (ev_kind != `FHEU_K_HARD);
    // vector error goes to hard fault
    if ((ev_kind == `FHEU_K_HARD) || escalate) begin
      target = `FHEU_K_HARD;
    end else begin
      target = ev_kind;
    end
    // hard fault beats all but nmi/hard
    // hard fault inside nmi or hard locks
    to_lock = ev_valid & (target == `FHEU_K_HARD) &
      ((i_cur_kind == `FHEU_K_NMI) || (i_cur_kind == `FHEU_K_HARD));
  end

  // ----------
  // status set and clear terms
  // ----------
  always @* begin
    cfs_clr = 32'h00000000;
    hfs_clr = 32'h00000000;
    if (wr_en && (dp_addr == `FHEU_OFS_COMBINED_STATUS)) begin
      cfs_clr = i_hwdata;
    end
    if (wr_en && (dp_addr == `FHEU_OFS_HARD_STATUS)) begin
      hfs_clr = i_hwdata;
    end
    cfs_set = ev_valid ? cause_flag(ev_cause) : 32'h00000000;
    // capture only while no address is held, or when its valid bit is cleared in the same cycle
    prot_capture = ev_valid & (ev_kind == `FHEU_K_PROTECT) &
      (~combined_fault_status_r[`FHEU_BIT_PROT_ADDR_VALID] |
       cfs_clr[`FHEU_BIT_PROT_ADDR_VALID]);
    bus_capture = ev_valid & (ev_kind == `FHEU_K_BUS) &
      (ev_cause != `FHEU_C_BUS_INEXACT) &
      (~combined_fault_status_r[`FHEU_BIT_BUS_ADDR_VALID] |
       cfs_clr[`FHEU_BIT_BUS_ADDR_VALID]);
    cfs_set[`FHEU_BIT_PROT_ADDR_VALID] = prot_capture;
    cfs_set[`FHEU_BIT_BUS_ADDR_VALID] = bus_capture;
    combined_fault_status_nxt = (combined_fault_status_r & ~cfs_clr) | cfs_set;
    hard_fault_status_nxt = hard_fault_status_r & ~hfs_clr;
    if (ev_valid && (ev_cause == `FHEU_C_VECTOR)) begin
      hard_fault_status_nxt[`FHEU_BIT_VECTOR_READ] = 1'b1;
    end
    if (ev_valid && escalate) begin
      hard_fault_status_nxt[`FHEU_BIT_ESCALATION] = 1'b1;
    end
  end

  // ----------
  // status and address registers
  // ----------
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      combined_fault_status_r <= `FHEU_RST_ZERO32;
      hard_fault_status_r <= `FHEU_RST_ZERO32;
      protect_fault_address_r <= `FHEU_RST_ZERO32;
      bus_fault_address_r <= `FHEU_RST_ZERO32;
    end else begin
      combined_fault_status_r <= combined_fault_status_nxt;
      hard_fault_status_r <= hard_fault_status_nxt;
      if (prot_capture) begin
        protect_fault_address_r <= i_fault_addr;
      end
      if (bus_capture) begin
        bus_fault_address_r <= i_fault_addr;
      end
    end
  end

  // ----------
  // software control registers
  // ----------
  // enables and priorities written by software
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      handler_enable_r <= `FHEU_RST_CTRL;
      prio_protect_r <= `FHEU_RST_PRIO;
      prio_bus_r <= `FHEU_RST_PRIO;
      prio_usage_r <= `FHEU_RST_PRIO;
    end else if (wr_en) begin
      if (dp_addr == `FHEU_OFS_HANDLER_CTRL) begin
        handler_enable_r <= i_hwdata[2:0];
      end
      if (dp_addr == `FHEU_OFS_HANDLER_PRIO) begin
        prio_protect_r <= i_hwdata[7:0];
        prio_bus_r <= i_hwdata[15:8];
        prio_usage_r <= i_hwdata[23:16];
      end
    end
  end

  // ----------
  // handler dispatch and lockup state
  // ----------
  // no instructions run while locked, so new faults are dropped then
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_take_valid <= 1'b0;
      o_take_handler <= `FHEU_K_THREAD;
      o_lockup <= 1'b0;
      lock_from_nmi_r <= 1'b0;
    end else begin
      o_take_valid <= ev_valid & ~to_lock;
      if (ev_valid && !to_lock) begin
        o_take_handler <= target;
      end
      if (o_lockup) begin
        if (i_debug_halt || (i_nmi && !lock_from_nmi_r)) begin
          o_lockup <= 1'b0;
          lock_from_nmi_r <= 1'b0;
        end
      end else if (to_lock) begin
        o_lockup <= 1'b1;
        lock_from_nmi_r <= (i_cur_kind == `FHEU_K_NMI);
      end
    end
  end

  // ----------
  // register read data
  // ----------
  // unmapped offsets read zero and still answer okay
  always @* begin
    o_hrdata = 32'h00000000;
    if (rd_en) begin
      case (dp_addr)
        `FHEU_OFS_COMBINED_STATUS: o_hrdata = combined_fault_status_r;
        `FHEU_OFS_HARD_STATUS: o_hrdata = hard_fault_status_r;
        `FHEU_OFS_PROTECT_ADDR: o_hrdata = protect_fault_address_r;
        `FHEU_OFS_BUS_ADDR: o_hrdata = bus_fault_address_r;
        `FHEU_OFS_HANDLER_CTRL: o_hrdata = {29'h00000000, handler_enable_r};
        `FHEU_OFS_HANDLER_PRIO: o_hrdata = {8'h00, prio_usage_r, prio_bus_r, prio_protect_r};
        `FHEU_OFS_CORE_STATE: o_hrdata = {30'h00000000, lock_from_nmi_r, o_lockup};
        default: o_hrdata = 32'h00000000;
      endcase
    end
  end

endmodule

// File: fheu_regs.vh
// register offsets, field positions, reset values and codes of the fault handling unit
`ifndef FHEU_REGS_VH
`define FHEU_REGS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define FHEU_OFS_COMBINED_STATUS 8'h00
`define FHEU_OFS_HARD_STATUS 8'h04
`define FHEU_OFS_PROTECT_ADDR 8'h08
`define FHEU_OFS_BUS_ADDR 8'h0C
`define FHEU_OFS_HANDLER_CTRL 8'h10
`define FHEU_OFS_HANDLER_PRIO 8'h14
`define FHEU_OFS_CORE_STATE 8'h18

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define FHEU_RST_ZERO32 32'h00000000
`define FHEU_RST_CTRL 3'h0
`define FHEU_RST_PRIO 8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define FHEU_BIT_PROT_ADDR_VALID 7
`define FHEU_BIT_BUS_ADDR_VALID 15
`define FHEU_BIT_VECTOR_READ 1
`define FHEU_BIT_ESCALATION 30
`define FHEU_BIT_EN_PROTECT 0
`define FHEU_BIT_EN_BUS 1
`define FHEU_BIT_EN_USAGE 2
`define FHEU_BIT_LOCKUP 0
`define FHEU_BIT_LOCK_FROM_NMI 1

// ---------------------------------------------------------------
// fault cause codes on i_fault_cause
// ---------------------------------------------------------------
`define FHEU_C_VECTOR 5'h00
`define FHEU_C_PROT_INSTR 5'h01
`define FHEU_C_PROT_DATA 5'h02
`define FHEU_C_PROT_STACK 5'h03
`define FHEU_C_PROT_UNSTACK 5'h04
`define FHEU_C_PROT_LAZY_FP 5'h05
`define FHEU_C_BUS_STACK 5'h06
`define FHEU_C_BUS_UNSTACK 5'h07
`define FHEU_C_BUS_PREFETCH 5'h08
`define FHEU_C_BUS_LAZY_FP 5'h09
`define FHEU_C_BUS_EXACT 5'h0A
`define FHEU_C_BUS_INEXACT 5'h0B
`define FHEU_C_USE_COPROC 5'h0C
`define FHEU_C_USE_UNDEF 5'h0D
`define FHEU_C_USE_BAD_STATE 5'h0E
`define FHEU_C_USE_BAD_RETURN 5'h0F
`define FHEU_C_USE_UNALIGNED 5'h10
`define FHEU_C_USE_ZERO_DIV 5'h11

// ---------------------------------------------------------------
// execution context and handler kinds
// ---------------------------------------------------------------
`define FHEU_K_THREAD 3'h0
`define FHEU_K_NMI 3'h1
`define FHEU_K_HARD 3'h2
`define FHEU_K_PROTECT 3'h3
`define FHEU_K_BUS 3'h4
`define FHEU_K_USAGE 3'h5
`define FHEU_K_OTHER 3'h6

// ---------------------------------------------------------------
// exception return code check
// ---------------------------------------------------------------
`define FHEU_RET_UPPER 27'h7FFFFFF
`define FHEU_RET_H_MSP 5'h11
`define FHEU_RET_T_MSP 5'h19
`define FHEU_RET_T_PSP 5'h1D
`define FHEU_RET_H_MSP_FP 5'h01
`define FHEU_RET_T_MSP_FP 5'h09
`define FHEU_RET_T_PSP_FP 5'h0D

`endif

// File: fheu_ahb_slave.v
// ahb-lite address and data phase tracking for the fault unit registers
`timescale 1ns/1ns
module fheu_ahb_slave (
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire i_hready,
  output wire o_hreadyout,
  output wire o_hresp,
  output wire o_wr_en,
  output wire o_rd_en,
  output wire [7:0] o_dp_addr
);

  reg dp_valid_r;
  reg dp_write_r;
  reg [7:0] dp_addr_r;

  // ---------------------------------------------------------------
  // address phase capture
  // ---------------------------------------------------------------
  // only whole-word nonseq/seq transfers are taken, others idle the data phase
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end else if (i_hready) begin
      dp_valid_r <= i_hsel & i_htrans[1] & (i_hsize == 3'h2);
      dp_write_r <= i_hwrite;
      dp_addr_r <= {i_haddr[7:2], 2'h0};
    end
  end

  // zero wait states, always okay
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_wr_en = dp_valid_r & dp_write_r;
  assign o_rd_en = dp_valid_r & ~dp_write_r;
  assign o_dp_addr = dp_addr_r;

endmodule

// File: fheu_escalate.v
// decides whether a configurable fault is escalated to hard fault
`timescale 1ns/1ns
`include "fheu_regs.vh"
module fheu_escalate (
  input wire [2:0] i_kind,
  input wire i_enabled,
  input wire [7:0] i_prio,
  input wire [2:0] i_cur_kind,
  input wire [7:0] i_cur_prio,
  input wire i_primask,
  input wire i_faultmask,
  input wire [7:0] i_basepri,
  input wire i_bus_handler_entry,
  output reg o_escalate
);

  reg in_handler;
  reg masked;

  // ---------------------------------------------------------------
  // escalation decision
  // ---------------------------------------------------------------
  // a synchronous fault cannot wait, so anything stopping entry escalates, except a bus fault raised on bus handler entry
  always @* begin
    in_handler = (i_cur_kind != `FHEU_K_THREAD);
    masked = i_primask | i_faultmask | ((i_basepri != 8'h00) & (i_prio >= i_basepri));
    o_escalate = masked;
    if (!i_enabled) begin
      o_escalate = 1'b1;
    end
    if (in_handler && (i_cur_kind == i_kind)) begin
      o_escalate = 1'b1;
    end
    if (in_handler && (i_prio >= i_cur_prio)) begin
      o_escalate = 1'b1;
    end
    if (i_bus_handler_entry && (i_kind == `FHEU_K_BUS)) begin
      o_escalate = 1'b0;
    end
  end

endmodule

// File: fheu_fault_props.sv
// concurrent checks on dispatch and lockup outputs of the fault unit
`timescale 1ns/1ns
`include "fheu_regs.vh"
module fheu_fault_props (
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_fault_valid,
  input wire [4:0] i_fault_cause,
  input wire i_bus_handler_entry,
  input wire i_ret_check,
  input wire i_bad_isa,
  input wire i_ici_bad_return,
  input wire [2:0] i_cur_kind,
  input wire i_nmi,
  input wire i_debug_halt,
  input wire o_take_valid,
  input wire [2:0] o_take_handler,
  input wire o_lockup
);
  default clocking dflt_cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // ----------------------------------------
  // helper terms and sequences
  // ----------------------------------------
  wire hard_ctx = (i_cur_kind == `FHEU_K_NMI) || (i_cur_kind == `FHEU_K_HARD);
  wire vec_in = i_fault_valid && (i_fault_cause == `FHEU_C_VECTOR) && !o_lockup;
  wire state_in = (i_bad_isa || i_ici_bad_return) && !i_fault_valid && !i_ret_check;
  // lockup entered from the nmi handler, seen one cycle later
  sequence nmi_lock_s;
    vec_in && (i_cur_kind == `FHEU_K_NMI) ##1 o_lockup;
  endsequence
  vector_hard_a: assert property (
    vec_in && !hard_ctx |=> o_take_valid && (o_take_handler == `FHEU_K_HARD))
    else $error("vector read error not sent to hard handler");
  lock_entry_a: assert property (
    vec_in && hard_ctx |=> o_lockup && !o_take_valid)
    else $error("hard fault in nmi or hard handler did not lock");
  locked_quiet_a: assert property (
    o_lockup |=> !o_take_valid)
    else $error("handler dispatched while locked");
  lock_hold_a: assert property (
    o_lockup && !i_nmi && !i_debug_halt |=> o_lockup)
    else $error("lockup left without release source");
  halt_release_a: assert property (
    o_lockup && i_debug_halt |=> $fell(o_lockup))
    else $error("debug halt did not release lockup");
  nmi_stays_a: assert property (
    nmi_lock_s ##1 (i_nmi && !i_debug_halt) |=> o_lockup)
    else $error("nmi released lockup entered from nmi");
  bus_entry_a: assert property (
    i_fault_valid && (i_fault_cause == `FHEU_C_BUS_STACK) && i_bus_handler_entry && !o_lockup
    |=> o_take_valid && (o_take_handler == `FHEU_K_BUS))
    else $error("bus handler entry fault escalated");
  take_cause_a: assert property (
    o_take_valid |-> $past(i_fault_valid || i_ret_check || i_bad_isa || i_ici_bad_return))
    else $error("handler dispatched without a fault");
  bad_state_a: assert property (
    state_in && !o_lockup && !hard_ctx |=> o_take_valid
    && ((o_take_handler == `FHEU_K_USAGE) || (o_take_handler == `FHEU_K_HARD)))
    else $error("bad state report not dispatched");
endmodule

// File: fheu_pipe_model.sv
// pipeline, protection check and bus side that reports faults to the unit
`timescale 1ns/1ns
module fheu_pipe_model (
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_go,
  input wire [1:0] i_kind,
  input wire [4:0] i_cause,
  input wire [31:0] i_data,
  output reg o_fault_valid,
  output reg [4:0] o_fault_cause,
  output reg [31:0] o_fault_addr,
  output reg o_ret_check,
  output reg [31:0] o_ret_value,
  output reg o_bad_isa,
  output reg o_ici_bad_return
);
  // one report per go; idle data flips to expose stale use
  // fault reports
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_fault_valid <= 1'b0;
      o_fault_cause <= 5'h00;
      o_fault_addr <= 32'h00000000;
      o_ret_check <= 1'b0;
      o_ret_value <= 32'h00000000;
      o_bad_isa <= 1'b0;
      o_ici_bad_return <= 1'b0;
    end else begin
      o_fault_valid <= i_go && (i_kind == 2'h0);
      o_ret_check <= i_go && (i_kind == 2'h1);
      o_bad_isa <= i_go && (i_kind == 2'h2);
      o_ici_bad_return <= i_go && (i_kind == 2'h3);
      o_fault_cause <= i_go ? i_cause : ~o_fault_cause;
      o_fault_addr <= i_go ? i_data : ~o_fault_addr;
      o_ret_value <= i_go ? i_data : ~o_ret_value;
    end
  end
endmodule

// File: tb_fheu_fault_unit.sv
// self-checking bench: register bus, fault causes, escalation and lockup
`timescale 1ns/1ns
`include "fheu_regs.vh"
module tb_fheu_fault_unit;
  reg ref_clk = 1'b0;
  reg reset = 1'b1;
  reg hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
  reg entry = 1'b0, hmode = 1'b0, primask = 1'b0, faultmask = 1'b0, nmi = 1'b0, halt = 1'b0;
  reg [31:0] haddr = 32'h00000000, hwdata = 32'h00000000, m_data = 32'h00000000, rdata;
  reg [1:0] htrans = 2'h0, m_kind = 2'h0;
  reg [2:0] hsize = 3'h2, kind = 3'h0;
  reg [7:0] prio = 8'h00, basepri = 8'h00;
  reg [4:0] m_cause = 5'h00;
  wire hready, hresp, fv, rc, bad_isa, interrupted_continuation_state, take, lock;
  wire [31:0] hrdata, fa, rv;
  wire [4:0] fc;
  wire [2:0] th;
  wire [29:0] rets = {`FHEU_RET_H_MSP, `FHEU_RET_T_MSP, `FHEU_RET_T_PSP,
    `FHEU_RET_H_MSP_FP, `FHEU_RET_T_MSP_FP, `FHEU_RET_T_PSP_FP};
  integer n_mismatch = 0, check_count = 0, c;
  initial forever #10 ref_clk = ~ref_clk;
  fheu_pipe_model pipe_u (.i_ref_clk(ref_clk), .i_reset(reset), .i_go(go), .i_kind(m_kind),
    .i_cause(m_cause), .i_data(m_data), .o_fault_valid(fv), .o_fault_cause(fc),
    .o_fault_addr(fa), .o_ret_check(rc), .o_ret_value(rv), .o_bad_isa(bad_isa),
    .o_ici_bad_return(interrupted_continuation_state));
  fheu_fault_unit dut_u (.i_ref_clk(ref_clk), .i_reset(reset), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .i_fault_valid(fv),
    .i_fault_cause(fc), .i_fault_addr(fa), .i_bus_handler_entry(entry), .i_ret_check(rc),
    .i_ret_value(rv), .i_handler_mode(hmode), .i_bad_isa(bad_isa), .i_ici_bad_return(interrupted_continuation_state),
    .i_cur_kind(kind), .i_cur_prio(prio), .i_primask(primask), .i_faultmask(faultmask),
    .i_basepri(basepri), .i_nmi(nmi), .i_debug_halt(halt), .o_take_valid(take),
    .o_take_handler(th), .o_lockup(lock));
  // ----------------------------------------
  // expectation helpers and access tasks
  // ----------------------------------------
  function [2:0] hk(input [4:0] f);
    hk = (f < 5'h06) ? `FHEU_K_PROTECT : (f < 5'h0C) ? `FHEU_K_BUS : `FHEU_K_USAGE;
  endfunction
  function [4:0] bi(input [4:0] f);
    bi = (f < 5'h06) ? f - 5'h01 : (f < 5'h0C) ? f + 5'h02 : f + 5'h04;
  endfunction
  task conclude;
    begin
      if (n_mismatch == 0 && check_count > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // bounded wait for hready; a stuck slave ends the run
  task tick;
    integer w;
    begin
      w = 0;
      @(posedge ref_clk);
      while (hready !== 1'b1) begin
        w = w + 1;
        if (w > 40) begin
          n_mismatch = n_mismatch + 1;
          conclude;
        end
        @(posedge ref_clk);
      end
    end
  endtask
  task xfer(input wr, input [7:0] ofs, input [31:0] wd);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, ofs};
      hwrite <= wr;
      tick;
      htrans <= 2'h0;
      hwdata <= wd;
      tick;
      rdata = hrdata;
    end
  endtask
  task rd_chk(input [7:0] ofs, input [31:0] mask, input [31:0] exp);
    begin
      xfer(1'b0, ofs, 32'h00000000);
      chk(rdata & mask, exp);
    end
  endtask
  task clear;
    begin
      xfer(1'b1, `FHEU_OFS_COMBINED_STATUS, 32'hFFFFFFFF);
      xfer(1'b1, `FHEU_OFS_HARD_STATUS, 32'hFFFFFFFF);
    end
  endtask
  task ctx(input [2:0] ck, input [7:0] cp);
    begin
      kind <= ck;
      prio <= cp;
    end
  endtask
  // one report; eh 0: no take, stale handler code ignored
  task fire(input [1:0] mk, input [4:0] mc, input [31:0] md, input [2:0] eh);
    begin
      go <= 1'b1;
      m_kind <= mk;
      m_cause <= mc;
      m_data <= md;
      @(posedge ref_clk);
      go <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk({take, th & {3{take}}}, (eh == 3'h0) ? 4'h0 : {1'b1, eh});
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    for (c = 0; c < 8; c = c + 1) begin
      rd_chk(c[7:0] << 2, 32'hFFFFFFFF, 32'h00000000);
    end
    // handlers disabled out of reset, so faults are escalation_flag to hard
    fire(2'h0, `FHEU_C_PROT_DATA, 32'h20000040, `FHEU_K_HARD);
    rd_chk(`FHEU_OFS_HARD_STATUS, 32'hFFFFFFFF, 32'h40000000);
    rd_chk(`FHEU_OFS_COMBINED_STATUS, 32'hFFFFFFFF, 32'h00000082);
    rd_chk(`FHEU_OFS_PROTECT_ADDR, 32'hFFFFFFFF, 32'h20000040);
    fire(2'h0, `FHEU_C_PROT_DATA, 32'h30000000, `FHEU_K_HARD);
    rd_chk(`FHEU_OFS_PROTECT_ADDR, 32'hFFFFFFFF, 32'h20000040);
    clear;
    rd_chk(`FHEU_OFS_COMBINED_STATUS, 32'hFFFFFFFF, 32'h00000000);
    fire(2'h0, `FHEU_C_VECTOR, 32'h00000000, `FHEU_K_HARD);
    rd_chk(`FHEU_OFS_HARD_STATUS, 32'hFFFFFFFF, 32'h00000002);
    xfer(1'b1, `FHEU_OFS_HANDLER_CTRL, 32'h00000007);
    xfer(1'b1, `FHEU_OFS_HANDLER_PRIO, 32'h00404040);
    rd_chk(`FHEU_OFS_HANDLER_PRIO, 32'h00FFFFFF, 32'h00404040);
    clear;
    // every cause code but vector from thread mode with all handlers on
    for (c = 1; c < 18; c = c + 1) begin
      fire(2'h0, c[4:0], 32'h10000000 + c, hk(c[4:0]));
      rd_chk(`FHEU_OFS_COMBINED_STATUS, 32'h003F3F1F, 32'h1 << bi(c[4:0]));
      if (c == 10) rd_chk(`FHEU_OFS_BUS_ADDR, 32'hFFFFFFFF, 32'h1000000A);
      clear;
    end
    hmode <= 1'b1;
    for (c = 0; c < 6; c = c + 1) begin
      fire(2'h1, 5'h00, {`FHEU_RET_UPPER, rets[c*5 +: 5]}, 3'h0);
    end
    fire(2'h1, 5'h00, 32'hFFFFFFF3, `FHEU_K_USAGE);
    fire(2'h1, 5'h00, 32'h7FFFFFF1, `FHEU_K_USAGE);
    fire(2'h2, 5'h00, 32'h00000000, `FHEU_K_USAGE);
    fire(2'h3, 5'h00, 32'h00000000, `FHEU_K_USAGE);
    rd_chk(`FHEU_OFS_COMBINED_STATUS, 32'h000C0000, 32'h000C0000);
    // escalation against the running handler, basepri and a disabled handler
    ctx(`FHEU_K_USAGE, 8'h40);
    fire(2'h0, `FHEU_C_USE_UNDEF, 32'h00000000, `FHEU_K_HARD);
    ctx(`FHEU_K_PROTECT, 8'h40);
    fire(2'h0, `FHEU_C_BUS_EXACT, 32'h50000000, `FHEU_K_HARD);
    ctx(`FHEU_K_OTHER, 8'h40);
    fire(2'h0, `FHEU_C_PROT_DATA, 32'h50000004, `FHEU_K_HARD);
    ctx(`FHEU_K_OTHER, 8'h80);
    fire(2'h0, `FHEU_C_PROT_DATA, 32'h50000004, `FHEU_K_PROTECT);
    fire(2'h0, `FHEU_C_VECTOR, 32'h00000000, `FHEU_K_HARD);
    ctx(`FHEU_K_BUS, 8'h40);
    entry <= 1'b1;
    fire(2'h0, `FHEU_C_BUS_STACK, 32'h50000008, `FHEU_K_BUS);
    entry <= 1'b0;
    fire(2'h0, `FHEU_C_BUS_STACK, 32'h50000008, `FHEU_K_HARD);
    ctx(`FHEU_K_THREAD, 8'h80);
    basepri <= 8'h40;
    fire(2'h0, `FHEU_C_USE_ZERO_DIV, 32'h00000000, `FHEU_K_HARD);
    basepri <= 8'h80;
    fire(2'h0, `FHEU_C_USE_ZERO_DIV, 32'h00000000, `FHEU_K_USAGE);
    basepri <= 8'h00;
    xfer(1'b1, `FHEU_OFS_HANDLER_CTRL, 32'h00000003);
    fire(2'h0, `FHEU_C_USE_ZERO_DIV, 32'h00000000, `FHEU_K_HARD);
    rd_chk(`FHEU_OFS_HARD_STATUS, 32'h40000000, 32'h40000000);
    // nmi lockup: nmi holds, halt frees; hard lockup: nmi frees, reset frees
    ctx(`FHEU_K_NMI, 8'h00);
    fire(2'h0, `FHEU_C_VECTOR, 32'h00000000, 3'h0);
    nmi <= 1'b1;
    @(posedge ref_clk);
    nmi <= 1'b0;
    fire(2'h0, `FHEU_C_PROT_DATA, 32'h60000000, 3'h0);
    chk(lock, 1'b1);
    rd_chk(`FHEU_OFS_CORE_STATE, 32'h00000003, 32'h00000003);
    halt <= 1'b1;
    @(posedge ref_clk);
    halt <= 1'b0;
    @(posedge ref_clk);
    chk(lock, 1'b0);
    ctx(`FHEU_K_HARD, 8'h00);
    fire(2'h0, `FHEU_C_PROT_DATA, 32'h60000004, 3'h0);
    rd_chk(`FHEU_OFS_CORE_STATE, 32'h00000003, 32'h00000001);
    nmi <= 1'b1;
    @(posedge ref_clk);
    nmi <= 1'b0;
    @(posedge ref_clk);
    chk(lock, 1'b0);
    fire(2'h0, `FHEU_C_VECTOR, 32'h00000000, 3'h0);
    reset <= 1'b1;
    @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk(lock, 1'b0);
    conclude;
  end
endmodule
bind fheu_fault_unit fheu_fault_props chk_u (.i_ref_clk, .i_reset, .i_fault_valid,
  .i_fault_cause, .i_bus_handler_entry, .i_ret_check, .i_bad_isa, .i_ici_bad_return,
  .i_cur_kind, .i_nmi, .i_debug_halt, .o_take_valid, .o_take_handler, .o_lockup);
